// *** scr_stats_bank.sv ***
// statistics record bank with an axi4-lite register slave
//
// Notes on behaviour
// RULE1 - event tally counts occurrences from zero
// RULE2 - smallest sample in bits 63:48, starts ones
// RULE3 - largest sample in bits 47:32, starts zeros
// RULE4 - bit 1 flags concurrency limit exceeded
// RULE5 - bit 0 flags a saturated measurement
// RULE6 - third word sums every measured value
// RULE7 - fourth word sums squared measured values
// RULE8 - full record words at 8-byte steps
// RULE9 - sum-only record reserves extremes word
// RULE10 - event-only record keeps just the tally
// RULE11 - request record counts all and distinct
// RULE12 - queue record counts empty clock cycles
// RULE13 - queue record counts push or pop updates
// RULE14 - queue peak depth in bits 47:32
// RULE15 - queue record sums depth on updates
// RULE16 - wide general value is read/write, resets zero
// RULE17 - overflow saturates values and sets flag; sum-only, event-only and request records saturate with no flag
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
module scr_stats_bank import scr_pkg::*; #(
    parameter int RAW_W = 32
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [SCR_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [SCR_DATA_W-1:0] s_axi_wdata,
    input wire logic [SCR_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [SCR_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [SCR_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // full event record source
    input wire logic ev_valid,
    input wire logic [RAW_W-1:0] ev_value,
    input wire logic ev_overlap,
    // sum-only event record source
    input wire logic so_valid,
    input wire logic [RAW_W-1:0] so_value,
    // event-only record source
    input wire logic eo_valid,
    // request record source
    input wire logic rq_valid,
    input wire logic rq_distinct,
    // queue record source, depth is the level after this cycle's update
    input wire logic q_push,
    input wire logic q_pop,
    input wire logic [SCR_VAL_W-1:0] q_depth,
    input wire logic q_overlap,
    // interrupt
    output logic irq
);

    // ---------------- full event record ----------------
    logic [63:0] ev_tally_q;
    logic [15:0] ev_min_q;
    logic [15:0] ev_max_q;
    logic ev_few_q;
    logic ev_sat_q;
    logic [63:0] ev_sum_q;
    logic [63:0] ev_sq_q;
    logic ev_clip;
    logic [15:0] ev_sample;
    logic [31:0] ev_square;
    logic [64:0] ev_tally_s;
    logic [64:0] ev_sum_s;
    logic [64:0] ev_sq_s;
    logic ev_sat_set;

    // a raw value wider than the field is pinned to all ones
    assign ev_clip = |ev_value[RAW_W-1:SCR_VAL_W]; // see RULE17
    assign ev_sample = ev_clip ? SCR_VAL_MAX : ev_value[SCR_VAL_W-1:0];
    assign ev_square = 32'(ev_sample) * 32'(ev_sample);
    assign ev_tally_s = scr_sat_add(ev_tally_q, SCR_ONE);
    assign ev_sum_s = scr_sat_add(ev_sum_q, {48'h0000_0000_0000, ev_sample});
    assign ev_sq_s = scr_sat_add(ev_sq_q, {32'h0000_0000, ev_square});
    assign ev_sat_set = ev_valid & (ev_clip | ev_tally_s[64] | ev_sum_s[64] | ev_sq_s[64]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_tally_q <= SCR_CNT_RST;
            ev_min_q <= SCR_MIN_RST;
            ev_max_q <= SCR_MAX_RST;
            ev_few_q <= 1'b0;
            ev_sat_q <= 1'b0;
            ev_sum_q <= SCR_CNT_RST;
            ev_sq_q <= SCR_CNT_RST;
        end else begin
            if (ev_valid) begin
                ev_tally_q <= ev_tally_s[63:0]; // see RULE1
                ev_sum_q <= ev_sum_s[63:0]; // see RULE6
                ev_sq_q <= ev_sq_s[63:0]; // see RULE7
                if (ev_sample < ev_min_q) begin
                    ev_min_q <= ev_sample; // see RULE2
                end
                if (ev_sample > ev_max_q) begin
                    ev_max_q <= ev_sample; // see RULE3
                end
            end
            ev_few_q <= ev_few_q | ev_overlap; // see RULE4
            ev_sat_q <= ev_sat_q | ev_sat_set; // see RULE5
        end
    end

    // ---------------- sum-only and event-only records ----------------
    logic [63:0] so_tally_q;
    logic [63:0] so_sum_q;
    logic [63:0] so_sq_q;
    logic [63:0] eo_tally_q;
    logic [15:0] so_sample;
    logic [31:0] so_square;
    logic [64:0] so_tally_s;
    logic [64:0] so_sum_s;
    logic [64:0] so_sq_s;
    logic [64:0] eo_tally_s;

    // no flag word here, so clipping is silent apart from the clamp
    assign so_sample = (|so_value[RAW_W-1:SCR_VAL_W]) ? SCR_VAL_MAX : so_value[SCR_VAL_W-1:0];
    assign so_square = 32'(so_sample) * 32'(so_sample);
    assign so_tally_s = scr_sat_add(so_tally_q, SCR_ONE);
    assign so_sum_s = scr_sat_add(so_sum_q, {48'h0000_0000_0000, so_sample});
    assign so_sq_s = scr_sat_add(so_sq_q, {32'h0000_0000, so_square});
    assign eo_tally_s = scr_sat_add(eo_tally_q, SCR_ONE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            so_tally_q <= SCR_CNT_RST;
            so_sum_q <= SCR_CNT_RST;
            so_sq_q <= SCR_CNT_RST;
            eo_tally_q <= SCR_CNT_RST;
        end else begin
            if (so_valid) begin
                so_tally_q <= so_tally_s[63:0]; // see RULE9
                so_sum_q <= so_sum_s[63:0]; // see RULE9
                so_sq_q <= so_sq_s[63:0]; // see RULE9
            end
            if (eo_valid) begin
                eo_tally_q <= eo_tally_s[63:0]; // see RULE10
            end
        end
    end

    // ---------------- request record ----------------
    logic [63:0] rq_tally_q;
    logic [63:0] rq_dist_q;
    logic [64:0] rq_tally_s;
    logic [64:0] rq_dist_s;

    assign rq_tally_s = scr_sat_add(rq_tally_q, SCR_ONE);
    assign rq_dist_s = scr_sat_add(rq_dist_q, SCR_ONE);

    // distinct counts only alongside a request, so it never passes the total
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rq_tally_q <= SCR_CNT_RST;
            rq_dist_q <= SCR_CNT_RST;
        end else if (rq_valid) begin
            rq_tally_q <= rq_tally_s[63:0]; // see RULE11
            if (rq_distinct) begin
                rq_dist_q <= rq_dist_s[63:0]; // see RULE11
            end
        end
    end

    // ---------------- queue record ----------------
    logic [63:0] q_idle_q;
    logic [63:0] q_upd_q;
    logic [15:0] q_peak_q;
    logic q_few_q;
    logic q_sat_q;
    logic [63:0] q_total_q;
    logic q_update;
    logic q_empty;
    logic [64:0] q_idle_s;
    logic [64:0] q_upd_s;
    logic [64:0] q_total_s;
    logic q_sat_set;

    assign q_update = q_push | q_pop;
    assign q_empty = (q_depth == SCR_MAX_RST);
    assign q_idle_s = scr_sat_add(q_idle_q, SCR_ONE);
    assign q_upd_s = scr_sat_add(q_upd_q, SCR_ONE);
    assign q_total_s = scr_sat_add(q_total_q, {48'h0000_0000_0000, q_depth});
    assign q_sat_set = (q_empty & q_idle_s[64])
                     | (q_update & (q_upd_s[64] | q_total_s[64])); // see RULE17

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_idle_q <= SCR_CNT_RST;
            q_upd_q <= SCR_CNT_RST;
            q_peak_q <= SCR_MAX_RST;
            q_few_q <= 1'b0;
            q_sat_q <= 1'b0;
            q_total_q <= SCR_CNT_RST;
        end else begin
            if (q_empty) begin
                q_idle_q <= q_idle_s[63:0]; // see RULE12
            end
            if (q_update) begin
                q_upd_q <= q_upd_s[63:0]; // see RULE13
                q_total_q <= q_total_s[63:0]; // see RULE15
                if (q_depth > q_peak_q) begin
                    q_peak_q <= q_depth; // see RULE14
                end
            end
            q_few_q <= q_few_q | q_overlap; // see RULE4
            q_sat_q <= q_sat_q | q_sat_set; // see RULE5
        end
    end

    // ---------------- read view of all 64-bit words ----------------
    logic [63:0] wide_q;
    logic [63:0] word_view [0:SCR_SLOTS-1];
    logic [63:0] ev_ext_word;
    logic [63:0] q_peak_word;

    // reserved bits of the flag words read as zero
    assign ev_ext_word = {ev_min_q, ev_max_q, 30'h0000_0000, ev_few_q, ev_sat_q}; // see RULE2
    assign q_peak_word = {16'h0000, q_peak_q, 30'h0000_0000, q_few_q, q_sat_q}; // see RULE14

    // slot index is byte address divided by eight
    assign word_view[0] = ev_tally_q; // see RULE8
    assign word_view[1] = ev_ext_word; // see RULE8
    assign word_view[2] = ev_sum_q; // see RULE8
    assign word_view[3] = ev_sq_q; // see RULE8
    assign word_view[4] = so_tally_q;
    assign word_view[5] = SCR_CNT_RST; // see RULE9
    assign word_view[6] = so_sum_q;
    assign word_view[7] = so_sq_q;
    assign word_view[8] = eo_tally_q;
    assign word_view[9] = SCR_CNT_RST; // see RULE10
    assign word_view[10] = SCR_CNT_RST; // see RULE10
    assign word_view[11] = SCR_CNT_RST; // see RULE10
    assign word_view[12] = rq_tally_q;
    assign word_view[13] = SCR_CNT_RST; // see RULE11
    assign word_view[14] = rq_dist_q;
    assign word_view[15] = SCR_CNT_RST; // see RULE11
    assign word_view[16] = q_idle_q;
    assign word_view[17] = q_upd_q;
    assign word_view[18] = q_peak_word;
    assign word_view[19] = q_total_q;
    assign word_view[20] = wide_q;
    generate
        for (genvar i = SCR_WORDS; i < SCR_SLOTS; i++) begin : g_unmapped
            assign word_view[i] = SCR_CNT_RST;
        end
    endgenerate

    // ---------------- axi4-lite write channel ----------------
    logic aw_full_q;
    logic w_full_q;
    logic [SCR_ADDR_W-1:0] aw_addr_q;
    logic [SCR_DATA_W-1:0] w_data_q;
    logic [SCR_STRB_W-1:0] w_strb_q;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic aw_full_d;
    logic w_full_d;
    logic bvalid_d;
    logic wr_lo;
    logic wr_hi;
    logic wr_stat;
    logic wr_mask;
    logic wr_ro;
    logic [SCR_IRQ_W-1:0] irq_stat_q;
    logic [SCR_IRQ_W-1:0] irq_mask_q;
    logic [SCR_IRQ_W-1:0] irq_evt;
    logic [SCR_IRQ_W-1:0] irq_clr;

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign aw_full_d = aw_full_q ? ~do_write : aw_take;
    assign w_full_d = w_full_q ? ~do_write : w_take;
    assign bvalid_d = do_write | (s_axi_bvalid & ~s_axi_bready);
    assign wr_lo = (aw_addr_q[7:2] == SCR_WIDE_LO[7:2]);
    assign wr_hi = (aw_addr_q[7:2] == SCR_WIDE_HI[7:2]);
    assign wr_stat = (aw_addr_q[7:2] == SCR_IRQ_STAT[7:2]);
    assign wr_mask = (aw_addr_q[7:2] == SCR_IRQ_MASK[7:2]);
    // counters are read-only: writes to them are dropped with an okay
    assign wr_ro = (aw_addr_q < SCR_WIDE_LO);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SCR_RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            s_axi_awready <= ~aw_full_d;
            s_axi_wready <= ~w_full_d;
            s_axi_bvalid <= bvalid_d;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= (wr_lo | wr_hi | wr_stat | wr_mask | wr_ro) ?
                               SCR_RESP_OKAY : SCR_RESP_SLVERR;
            end
        end
    end

    // ---------------- wide value and interrupt registers ----------------
    assign irq_evt[SCR_IRQ_EV_SAT] = ev_sat_set;
    assign irq_evt[SCR_IRQ_EV_FEW] = ev_overlap;
    assign irq_evt[SCR_IRQ_Q_SAT] = q_sat_set;
    assign irq_evt[SCR_IRQ_Q_FEW] = q_overlap;
    assign irq_clr = (do_write & wr_stat) ? (w_data_q[SCR_IRQ_W-1:0] & {SCR_IRQ_W{w_strb_q[0]}})
                                          : SCR_IRQ_RST;

    // an event in the clearing cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wide_q <= SCR_CNT_RST;
            irq_stat_q <= SCR_IRQ_RST;
            irq_mask_q <= SCR_IRQ_RST;
            irq <= 1'b0;
        end else begin
            if (do_write & wr_lo) begin
                wide_q[31:0] <= scr_merge(wide_q[31:0], w_data_q, w_strb_q); // see RULE16
            end
            if (do_write & wr_hi) begin
                wide_q[63:32] <= scr_merge(wide_q[63:32], w_data_q, w_strb_q); // see RULE16
            end
            if (do_write & wr_mask & w_strb_q[0]) begin
                irq_mask_q <= w_data_q[SCR_IRQ_W-1:0];
            end
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ---------------- axi4-lite read channel ----------------
    logic ar_take;
    logic rvalid_d;
    logic [4:0] rd_idx;
    logic [63:0] rd_word;
    logic [31:0] rd_data;
    logic [1:0] rd_resp;

    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
    assign rd_idx = s_axi_araddr[7:3];
    assign rd_word = word_view[rd_idx];

    // no snapshot: a 64-bit counter read as two halves can tear while counting
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_resp = SCR_RESP_OKAY;
        if (s_axi_araddr < SCR_IRQ_STAT && s_axi_araddr[7:3] < 5'(SCR_WORDS)) begin
            rd_data = s_axi_araddr[2] ? rd_word[63:32] : rd_word[31:0];
        end else if (s_axi_araddr[7:2] == SCR_IRQ_STAT[7:2]) begin
            rd_data = {28'h000_0000, irq_stat_q};
        end else if (s_axi_araddr[7:2] == SCR_IRQ_MASK[7:2]) begin
            rd_data = {28'h000_0000, irq_mask_q};
        end else begin
            rd_resp = SCR_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SCR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid <= rvalid_d;
            if (ar_take) begin
                s_axi_rdata <= rd_data;
                s_axi_rresp <= rd_resp;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    tally_count_a: assert property (ev_valid && ev_tally_q != SCR_ALL_ONES |=> // see RULE1
        ev_tally_q == $past(ev_tally_q) + SCR_ONE) else $error("event tally did not step");
    min_track_a: assert property (ev_valid |=> // see RULE2
        ev_min_q <= $past(ev_sample) && ev_min_q <= $past(ev_min_q)) else $error("min wrong");
    max_track_a: assert property (ev_valid |=> // see RULE3
        ev_max_q >= $past(ev_sample) && ev_max_q >= $past(ev_max_q)) else $error("max wrong");
    few_flag_a: assert property (ev_overlap |=> ev_few_q) // see RULE4
        else $error("concurrency flag not set");
    clip_sat_a: assert property (ev_valid && ev_clip |=> // see RULE5
        ev_sat_q && ev_max_q == SCR_VAL_MAX) else $error("clipped sample not flagged");
    sum_add_a: assert property (ev_valid && !ev_sum_s[64] |=> // see RULE6
        ev_sum_q == $past(ev_sum_q) + {48'h0000_0000_0000, $past(ev_sample)})
        else $error("value total wrong");
    square_add_a: assert property (ev_valid && !ev_sq_s[64] |=> // see RULE7
        ev_sq_q == $past(ev_sq_q) + {32'h0000_0000, $past(ev_square)})
        else $error("squared total wrong");
    distinct_bound_a: assert property (rq_dist_q <= rq_tally_q) // see RULE11
        else $error("distinct count exceeds total");
    idle_count_a: assert property (!q_empty |=> q_idle_q == $past(q_idle_q)) // see RULE12
        else $error("idle count moved while queue busy");
    depth_total_a: assert property (q_update && !q_total_s[64] |=> // see RULE15
        q_total_q == $past(q_total_q) + {48'h0000_0000_0000, $past(q_depth)})
        else $error("queue depth total wrong");
    wide_write_a: assert property (do_write && wr_hi && w_strb_q == 4'hF |=> // see RULE16
        wide_q[63:32] == $past(w_data_q)) else $error("wide value not written");
    irq_level_a: assert property (irq == $past(|(irq_stat_q & irq_mask_q)))
        else $error("interrupt level wrong");
    write_resp_a: assert property (do_write |=> s_axi_bvalid) else $error("no write response");
    read_resp_a: assert property (ar_take |=> s_axi_rvalid) else $error("no read response");

    clip_seen_c: cover property (ev_valid && ev_clip);
    queue_update_c: cover property (q_push && q_pop);
    irq_raise_c: cover property ($rose(irq));
    wide_read_c: cover property (ar_take && s_axi_araddr == SCR_WIDE_HI);

endmodule : scr_stats_bank

// *** scr_pkg.sv ***
// constants, field layout and helpers shared by the statistics record bank
package scr_pkg;
    // bus geometry
    localparam int SCR_ADDR_W = 8;
    localparam int SCR_DATA_W = 32;
    localparam int SCR_STRB_W = 4;
    // measured value and queue depth field width
    localparam int SCR_VAL_W = 16;
    localparam logic [15:0] SCR_VAL_MAX = 16'hFFFF;
    // record and register base byte addresses, each record four 64-bit words
    localparam logic [7:0] SCR_FULL_BASE = 8'h00;
    localparam logic [7:0] SCR_SUMO_BASE = 8'h20;
    localparam logic [7:0] SCR_EVTO_BASE = 8'h40;
    localparam logic [7:0] SCR_REQ_BASE = 8'h60;
    localparam logic [7:0] SCR_QUEUE_BASE = 8'h80;
    localparam logic [7:0] SCR_WIDE_LO = 8'hA0;
    localparam logic [7:0] SCR_WIDE_HI = 8'hA4;
    localparam logic [7:0] SCR_IRQ_STAT = 8'hC0;
    localparam logic [7:0] SCR_IRQ_MASK = 8'hC4;
    // word offsets inside a record
    localparam logic [7:0] SCR_OFS_W0 = 8'h00;
    localparam logic [7:0] SCR_OFS_W1 = 8'h08;
    localparam logic [7:0] SCR_OFS_W2 = 8'h10;
    localparam logic [7:0] SCR_OFS_W3 = 8'h18;
    // 64-bit word slots mapped below the interrupt registers
    localparam int SCR_WORDS = 21;
    localparam int SCR_SLOTS = 32;
    // field positions of the extremes and peak words
    localparam int SCR_MIN_LSB = 48;
    localparam int SCR_MAX_LSB = 32;
    localparam int SCR_FEW_BIT = 1;
    localparam int SCR_SAT_BIT = 0;
    // values after reset
    localparam logic [63:0] SCR_CNT_RST = 64'h0000_0000_0000_0000;
    localparam logic [15:0] SCR_MIN_RST = 16'hFFFF;
    localparam logic [15:0] SCR_MAX_RST = 16'h0000;
    localparam logic [63:0] SCR_ONE = 64'h0000_0000_0000_0001;
    localparam logic [63:0] SCR_ALL_ONES = 64'hFFFF_FFFF_FFFF_FFFF;
    // interrupt status bits
    localparam int SCR_IRQ_W = 4;
    localparam int SCR_IRQ_EV_SAT = 0;
    localparam int SCR_IRQ_EV_FEW = 1;
    localparam int SCR_IRQ_Q_SAT = 2;
    localparam int SCR_IRQ_Q_FEW = 3;
    localparam logic [3:0] SCR_IRQ_RST = 4'h0;
    // bus responses
    localparam logic [1:0] SCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCR_RESP_SLVERR = 2'h2;

    // saturating 64-bit add, top bit flags that the sum was clipped
    function automatic logic [64:0] scr_sat_add(input logic [63:0] a, input logic [63:0] b);
        logic [64:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[64] ? {1'b1, SCR_ALL_ONES} : s;
    endfunction : scr_sat_add

    // byte-lane merge of a 32-bit write
    function automatic logic [31:0] scr_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : scr_merge
endpackage : scr_pkg

// *** scr_stats_bank_test.sv ***
// self-checking bench for the statistics record bank over axi4-lite
`timescale 1ns/1ps
module scr_stats_bank_test import scr_pkg::*;;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] ev_value = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic ev_valid = 1'h0, ev_overlap = 1'h0, so_valid = 1'h0, eo_valid = 1'h0;
    logic rq_valid = 1'h0, rq_distinct = 1'h0, q_push = 1'h0, q_pop = 1'h0, q_overlap = 1'h0;
    // depth starts nonzero so the idle tally stays at zero until the test asks for it
    logic [15:0] q_depth = 16'h0001;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;

    always #2.5 aclk = ~aclk;

    scr_stats_bank i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ev_valid(ev_valid), .ev_value(ev_value), .ev_overlap(ev_overlap),
        .so_valid(so_valid), .so_value(ev_value), .eo_valid(eo_valid),
        .rq_valid(rq_valid), .rq_distinct(rq_distinct), .q_push(q_push), .q_pop(q_pop),
        .q_depth(q_depth), .q_overlap(q_overlap), .irq(irq));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // a hang anywhere ends up here as one mismatch
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // address and data offered together, each released on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic ah, wh, ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            @(posedge aclk);
            if (ah) awvalid <= 1'h0;
            if (wh) wvalid <= 1'h0;
            ad = ad | ah;
            wd = wd | wh;
        end
        do @(negedge aclk); while (bvalid !== 1'h1);
        chk({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge aclk); while (arready !== 1'h1);
        @(posedge aclk);
        arvalid <= 1'h0;
        do @(negedge aclk); while (rvalid !== 1'h1);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
        rready <= 1'h0;
    endtask : rd

    // k selects full, sum-only or event-only record
    task automatic ev(input int k, input logic [31:0] v);
        @(posedge aclk);
        ev_valid <= (k == 0);
        so_valid <= (k == 1);
        eo_valid <= (k == 2);
        ev_value <= v;
        @(posedge aclk);
        {ev_valid, so_valid, eo_valid} <= 3'h0;
    endtask : ev

    task automatic qu(input logic p, input logic o, input logic [15:0] d);
        @(posedge aclk);
        q_push <= p;
        q_pop <= o;
        q_depth <= d;
        @(posedge aclk);
        q_push <= 1'h0;
        q_pop <= 1'h0;
    endtask : qu

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        rd(8'h0C, 32'hFFFF_0000, SCR_RESP_OKAY);
        rd(8'h00, 32'h0000_0000, SCR_RESP_OKAY);
        rd(SCR_WIDE_LO, 32'h0000_0000, SCR_RESP_OKAY);
        $display("test reset done");
        ev(0, 32'h0000_0005);
        ev(0, 32'h0000_0003);
        rd(8'h00, 32'h0000_0002, SCR_RESP_OKAY);
        rd(8'h0C, 32'h0003_0005, SCR_RESP_OKAY);
        rd(8'h08, 32'h0000_0000, SCR_RESP_OKAY);
        rd(8'h10, 32'h0000_0008, SCR_RESP_OKAY);
        rd(8'h18, 32'h0000_0022, SCR_RESP_OKAY);
        // an over-wide sample clamps to the field maximum
        ev(0, 32'h0001_0000);
        @(posedge aclk) ev_overlap <= 1'h1;
        @(posedge aclk) ev_overlap <= 1'h0;
        rd(8'h0C, 32'h0003_FFFF, SCR_RESP_OKAY);
        rd(8'h08, 32'h0000_0003, SCR_RESP_OKAY);
        rd(8'h10, 32'h0001_0007, SCR_RESP_OKAY);
        rd(8'h18, 32'hFFFE_0023, SCR_RESP_OKAY);
        rd(8'h1C, 32'h0000_0000, SCR_RESP_OKAY);
        $display("test full record done");
        ev(1, 32'h0000_0004);
        ev(1, 32'h0000_0007);
        rd(8'h20, 32'h0000_0002, SCR_RESP_OKAY);
        rd(8'h28, 32'h0000_0000, SCR_RESP_OKAY);
        rd(8'h30, 32'h0000_000B, SCR_RESP_OKAY);
        rd(8'h38, 32'h0000_0041, SCR_RESP_OKAY);
        for (int i = 0; i < 3; i++) ev(2, 32'h0000_0000);
        rd(8'h40, 32'h0000_0003, SCR_RESP_OKAY);
        for (int i = 1; i < 4; i++) rd(8'h40 + 8'(i * 8), 32'h0000_0000, SCR_RESP_OKAY);
        // last pass has distinct without a request, which must be ignored
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            rq_valid <= (i < 3);
            rq_distinct <= (i != 1);
        end
        @(posedge aclk) {rq_valid, rq_distinct} <= 2'h0;
        rd(8'h60, 32'h0000_0003, SCR_RESP_OKAY);
        rd(8'h70, 32'h0000_0002, SCR_RESP_OKAY);
        rd(8'h68, 32'h0000_0000, SCR_RESP_OKAY);
        rd(8'h78, 32'h0000_0000, SCR_RESP_OKAY);
        $display("test event records done");
        @(posedge aclk) q_depth <= 16'h0000;
        repeat (5) @(posedge aclk);
        q_depth <= 16'h0001;
        qu(1'h1, 1'h0, 16'h0002);
        qu(1'h1, 1'h0, 16'h0003);
        qu(1'h0, 1'h1, 16'h0002);
        qu(1'h1, 1'h1, 16'h0002);
        @(posedge aclk) q_overlap <= 1'h1;
        @(posedge aclk) q_overlap <= 1'h0;
        rd(8'h80, 32'h0000_0005, SCR_RESP_OKAY);
        rd(8'h88, 32'h0000_0004, SCR_RESP_OKAY);
        rd(8'h94, 32'h0000_0003, SCR_RESP_OKAY);
        rd(8'h90, 32'h0000_0002, SCR_RESP_OKAY);
        rd(8'h98, 32'h0000_0009, SCR_RESP_OKAY);
        $display("test queue record done");
        wr(SCR_WIDE_LO, 32'h1234_5678, 4'hF, SCR_RESP_OKAY);
        wr(SCR_WIDE_HI, 32'h9ABC_DEF0, 4'hF, SCR_RESP_OKAY);
        wr(SCR_WIDE_LO, 32'h0000_00FF, 4'h1, SCR_RESP_OKAY);
        rd(SCR_WIDE_LO, 32'h1234_56FF, SCR_RESP_OKAY);
        rd(SCR_WIDE_HI, 32'h9ABC_DEF0, SCR_RESP_OKAY);
        wr(8'h00, 32'hFFFF_FFFF, 4'hF, SCR_RESP_OKAY);
        rd(8'h00, 32'h0000_0003, SCR_RESP_OKAY);
        wr(8'hA8, 32'hFFFF_FFFF, 4'hF, SCR_RESP_SLVERR);
        rd(8'hB0, 32'h0000_0000, SCR_RESP_SLVERR);
        $display("test bus access done");
        rd(SCR_IRQ_STAT, 32'h0000_000B, SCR_RESP_OKAY);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(SCR_IRQ_MASK, 32'h0000_0001, 4'hF, SCR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(SCR_IRQ_STAT, 32'h0000_0001, 4'hF, SCR_RESP_OKAY);
        rd(SCR_IRQ_STAT, 32'h0000_000A, SCR_RESP_OKAY);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(SCR_IRQ_MASK, 32'h0000_0008, 4'hF, SCR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        $display("test interrupt done");
        summarize();
    end
endmodule : scr_stats_bank_test
